// ==== csu_pkg.sv ====
// csu_pkg: constants, opcodes and types for the conditional skip unit
package csu_pkg;

  // ==========================================================
  // widths
  localparam int DW = 8;
  localparam int MEM_AW = 7;
  localparam int OP_W = 4;
  localparam int BIT_W = 3;
  localparam int REG_AW = 8;

  // ==========================================================
  // opcodes of the skip group
  localparam logic [3:0] OP_CEQ_IMM = 4'h0;
  localparam logic [3:0] OP_CEQ_MEM = 4'h1;
  localparam logic [3:0] OP_CNE_MEM = 4'h2;
  localparam logic [3:0] OP_CNE_IMM = 4'h3;
  localparam logic [3:0] OP_TLO_IO = 4'h4;
  localparam logic [3:0] OP_THI_IO = 4'h5;
  localparam logic [3:0] OP_TLO_MEM = 4'h6;
  localparam logic [3:0] OP_THI_MEM = 4'h7;
  localparam logic [3:0] OP_INC_ACC = 4'h8;
  localparam logic [3:0] OP_DEC_ACC = 4'h9;
  localparam logic [3:0] OP_INC_MEM = 4'hA;
  localparam logic [3:0] OP_DEC_MEM = 4'hB;

  // ==========================================================
  // flag bit positions
  localparam int FLG_Z = 0;
  localparam int FLG_C = 1;
  localparam int FLG_AC = 2;
  localparam int FLG_OV = 3;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_SKIPCNT = 8'h03;
  localparam logic [7:0] REG_MADDR = 8'h04;
  localparam logic [7:0] REG_MDATA = 8'h05;

  // ==========================================================
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {CSU_ST_IDLE, CSU_ST_EXEC, CSU_ST_SKIP} csu_state_t;

endpackage : csu_pkg

// ==== csu_mem_if.sv ====
// csu_mem_if: core and software ports of the data memory
`timescale 1ns/10ps
interface csu_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  // ==========================================================
  // core port
  logic a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  // ==========================================================
  // software port
  logic b_we;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;

  modport user (output a_we, a_addr, a_wdata, input a_rdata,
                output b_we, b_addr, b_wdata, input b_rdata);
  modport mem (input a_we, a_addr, a_wdata, output a_rdata,
               input b_we, b_addr, b_wdata, output b_rdata);
endinterface : csu_mem_if

// ==== csu_dmem.sv ====
// csu_dmem: two-port data memory with registered read data
`timescale 1ns/10ps
module csu_dmem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ports
  csu_mem_if.mem mp
);
  logic [DW-1:0] ram [0:(1<<AW)-1];

  // ==========================================================
  // write: core port wins a same-address collision
  always_ff @(posedge clk) begin
    if (mp.b_we && !(mp.a_we && mp.a_addr == mp.b_addr)) begin
      ram[mp.b_addr] <= mp.b_wdata;
    end
    if (mp.a_we) begin
      ram[mp.a_addr] <= mp.a_wdata;
    end
  end

  // ==========================================================
  // read: old data on a read-during-write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mp.a_rdata <= '0;
      mp.b_rdata <= '0;
    end else begin
      mp.a_rdata <= ram[mp.a_addr];
      mp.b_rdata <= ram[mp.b_addr];
    end
  end
endmodule : csu_dmem

// ==== csu_top.sv ====
// csu_top: execution of the compare, bit-test and count-and-skip instructions
`timescale 1ns/10ps
module csu_top #(
  parameter int MEM_AW = csu_pkg::MEM_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [3:0] instr_op,
  input wire logic [7:0] instr_imm,
  input wire logic [MEM_AW-1:0] instr_maddr,
  input wire logic [2:0] instr_bit,
  input wire logic [7:0] io_value,
  output logic instr_ready,
  // results
  output logic exec_done,
  output logic skip_req,
  output logic squash,
  output logic [7:0] accumulator,
  output logic [3:0] flags
);

  // ==========================================================
  // helpers
  function automatic logic uses_mem(input logic [3:0] op);
    return op == csu_pkg::OP_CEQ_MEM || op == csu_pkg::OP_CNE_MEM ||
           op == csu_pkg::OP_TLO_MEM || op == csu_pkg::OP_THI_MEM ||
           op == csu_pkg::OP_INC_MEM || op == csu_pkg::OP_DEC_MEM;
  endfunction : uses_mem

  // result in [7:0], flags {ov, ac, c, z} in [11:8]
  function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic sub);
    logic [8:0] r9;
    logic [4:0] r5;
    logic ov;
    r9 = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    r5 = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
    ov = sub ? ((a[7] ^ b[7]) & (a[7] ^ r9[7])) : (~(a[7] ^ b[7]) & (a[7] ^ r9[7]));
    return {ov, r5[4], r9[8], r9[7:0] == 8'h00, r9[7:0]};
  endfunction : alu

  // ==========================================================
  // state
  csu_pkg::csu_state_t st_q, st_d;
  logic [3:0] op_q;
  logic [7:0] imm_q;
  logic [MEM_AW-1:0] maddr_q;
  logic [2:0] bit_q;
  logic [7:0] io_q;
  logic [7:0] acc_q, acc_d;
  logic [3:0] flags_q, flags_d;
  logic skip_q, done_q, squash_q, ready_q;
  logic [7:0] rd_data_q, rd_data_d;
  logic [MEM_AW-1:0] memaddr_q;
  logic [7:0] skipcnt_q;

  csu_mem_if #(.AW(MEM_AW), .DW(8)) mif ();

  csu_dmem #(.AW(MEM_AW), .DW(8)) u_dmem (
    .clk(clk),
    .rst_b(rst_b),
    .mp(mif.mem)
  );

  // ==========================================================
  // decode
  wire take = (st_q == csu_pkg::CSU_ST_IDLE) && instr_valid;
  wire exec = (st_q == csu_pkg::CSU_ST_EXEC);
  wire mem_op = uses_mem(op_q);
  wire is_ceq = (op_q == csu_pkg::OP_CEQ_IMM) || (op_q == csu_pkg::OP_CEQ_MEM);
  wire is_cne = (op_q == csu_pkg::OP_CNE_IMM) || (op_q == csu_pkg::OP_CNE_MEM);
  wire is_tlo = (op_q == csu_pkg::OP_TLO_IO) || (op_q == csu_pkg::OP_TLO_MEM);
  wire is_thi = (op_q == csu_pkg::OP_THI_IO) || (op_q == csu_pkg::OP_THI_MEM);
  wire is_inc = (op_q == csu_pkg::OP_INC_ACC) || (op_q == csu_pkg::OP_INC_MEM);
  wire is_dec = (op_q == csu_pkg::OP_DEC_ACC) || (op_q == csu_pkg::OP_DEC_MEM);
  wire acc_upd = (op_q == csu_pkg::OP_INC_ACC) || (op_q == csu_pkg::OP_DEC_ACC);
  wire mem_upd = (op_q == csu_pkg::OP_INC_MEM) || (op_q == csu_pkg::OP_DEC_MEM);
  wire is_cmp = is_ceq || is_cne;
  wire flags_we = is_cmp || is_inc || is_dec;

  // ==========================================================
  // datapath
  wire [7:0] opnd = mem_op ? mif.a_rdata : imm_q;
  wire [7:0] alu_a = mem_upd ? mif.a_rdata : acc_q;
  wire [7:0] alu_b = is_cmp ? opnd : 8'h01;
  wire [11:0] alu_out = alu(alu_a, alu_b, !is_inc);
  wire [7:0] res = alu_out[7:0];
  wire [3:0] new_flags = alu_out[11:8];
  wire [7:0] tsrc = mem_op ? mif.a_rdata : io_q;
  wire tbit = tsrc[bit_q];
  wire eq = (acc_q == opnd);
  wire zero_res = (res == 8'h00);
  wire cond = is_ceq ? eq :
              is_cne ? !eq :
              is_tlo ? !tbit :
              is_thi ? tbit :
              (is_inc || is_dec) ? zero_res : 1'b0;

  // ==========================================================
  // sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      csu_pkg::CSU_ST_IDLE: begin
        if (take) begin
          st_d = csu_pkg::CSU_ST_EXEC;
        end
      end
      csu_pkg::CSU_ST_EXEC: begin
        // second instruction cycle only when skipping
        st_d = cond ? csu_pkg::CSU_ST_SKIP : csu_pkg::CSU_ST_IDLE;
      end
      csu_pkg::CSU_ST_SKIP: begin
        // the fetched follower is dropped here, not decoded
        st_d = csu_pkg::CSU_ST_IDLE;
      end
      default: begin
        st_d = csu_pkg::CSU_ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // memory ports
  wire wr_acc = reg_wr && (reg_addr == csu_pkg::REG_ACC);
  wire wr_flg = reg_wr && (reg_addr == csu_pkg::REG_FLAGS);
  wire wr_madr = reg_wr && (reg_addr == csu_pkg::REG_MADDR);
  wire wr_mdat = reg_wr && (reg_addr == csu_pkg::REG_MDATA);

  // read issued while idle so the byte is ready in the exec cycle
  assign mif.a_addr = exec ? maddr_q : instr_maddr;
  assign mif.a_we = exec && mem_upd;
  assign mif.a_wdata = res;
  // new window address reaches the memory at once, so a read may follow
  assign mif.b_addr = wr_madr ? reg_wdata[MEM_AW-1:0] : memaddr_q;
  assign mif.b_we = wr_mdat;
  assign mif.b_wdata = reg_wdata;

  // ==========================================================
  // accumulator and flags: core update wins over software
  assign acc_d = (exec && acc_upd) ? res : wr_acc ? reg_wdata : acc_q;
  assign flags_d = (exec && flags_we) ? new_flags : wr_flg ? reg_wdata[3:0] : flags_q;

  // ==========================================================
  // register read mux
  wire [7:0] status_w = {5'h00, !ready_q, squash_q, skip_q};
  wire [7:0] rd_mux = (reg_addr == csu_pkg::REG_ACC) ? acc_q :
                      (reg_addr == csu_pkg::REG_FLAGS) ? {4'h0, flags_q} :
                      (reg_addr == csu_pkg::REG_STATUS) ? status_w :
                      (reg_addr == csu_pkg::REG_SKIPCNT) ? skipcnt_q :
                      (reg_addr == csu_pkg::REG_MADDR) ? {{(8 - MEM_AW){1'b0}}, memaddr_q} :
                      (reg_addr == csu_pkg::REG_MDATA) ? mif.b_rdata : 8'h00;
  assign rd_data_d = reg_rd ? rd_mux : 8'h00;

  // ==========================================================
  // flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= csu_pkg::CSU_ST_IDLE;
      acc_q <= csu_pkg::ACC_RST;
      flags_q <= csu_pkg::FLAGS_RST;
      rd_data_q <= csu_pkg::BYTE_RST;
      memaddr_q <= '0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      rd_data_q <= rd_data_d;
      memaddr_q <= wr_madr ? reg_wdata[MEM_AW-1:0] : memaddr_q;
      ready_q <= (st_d == csu_pkg::CSU_ST_IDLE);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= 4'h0;
      imm_q <= csu_pkg::BYTE_RST;
      maddr_q <= '0;
      bit_q <= 3'h0;
      io_q <= csu_pkg::BYTE_RST;
    end else if (take) begin
      op_q <= instr_op;
      imm_q <= instr_imm;
      maddr_q <= instr_maddr;
      bit_q <= instr_bit;
      io_q <= io_value;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
      squash_q <= 1'b0;
      skipcnt_q <= csu_pkg::BYTE_RST;
    end else begin
      done_q <= exec;
      skip_q <= exec ? cond : skip_q;
      squash_q <= exec && cond;
      skipcnt_q <= (exec && cond) ? skipcnt_q + 8'h01 : skipcnt_q;
    end
  end

  assign reg_rdata = rd_data_q;
  assign instr_ready = ready_q;
  assign exec_done = done_q;
  assign skip_req = skip_q;
  assign squash = squash_q;
  assign accumulator = acc_q;
  assign flags = flags_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire sw_acc = wr_acc;
  wire sw_flg = wr_flg;

  sequence s_squash_once;
    squash_q && !ready_q ##1 !squash_q && ready_q;
  endsequence

  chk_ceq_imm_skip: assert property (
    exec && op_q == csu_pkg::OP_CEQ_IMM |=> skip_q == ($past(acc_q) == $past(imm_q)))
    else $error("equal-immediate skip wrong");
  chk_ceq_mem_skip: assert property (
    exec && op_q == csu_pkg::OP_CEQ_MEM |=> skip_q == ($past(acc_q) == $past(mif.a_rdata)))
    else $error("equal-memory skip wrong");
  chk_cne_mem_skip: assert property (
    exec && op_q == csu_pkg::OP_CNE_MEM |=> skip_q == ($past(acc_q) != $past(mif.a_rdata)))
    else $error("unequal-memory skip wrong");
  chk_cne_imm_skip: assert property (
    exec && op_q == csu_pkg::OP_CNE_IMM |=> skip_q == ($past(acc_q) != $past(imm_q)))
    else $error("unequal-immediate skip wrong");
  chk_cmp_flags_acc: assert property (
    exec && is_cmp && !sw_acc |=> acc_q == $past(acc_q) &&
      flags_q[csu_pkg::FLG_Z] == ($past(acc_q) == $past(opnd)) &&
      flags_q[csu_pkg::FLG_C] == ($past(acc_q) < $past(opnd)))
    else $error("compare flags or accumulator wrong");
  chk_io_low_skip: assert property (
    exec && op_q == csu_pkg::OP_TLO_IO && !sw_flg |=>
      skip_q == !$past(tbit) && $stable(flags_q))
    else $error("io low test wrong");
  chk_io_high_skip: assert property (
    exec && op_q == csu_pkg::OP_THI_IO && !sw_flg |=>
      skip_q == $past(io_q[bit_q]) && $stable(flags_q))
    else $error("io high test wrong");
  chk_mem_low_skip: assert property (
    exec && op_q == csu_pkg::OP_TLO_MEM && !sw_flg |=>
      skip_q == !$past(tbit) && $stable(flags_q))
    else $error("memory low test wrong");
  chk_mem_high_skip: assert property (
    exec && op_q == csu_pkg::OP_THI_MEM && !sw_flg |=>
      skip_q == $past(tbit) && $stable(flags_q))
    else $error("memory high test wrong");
  chk_inc_acc_zero: assert property (
    exec && op_q == csu_pkg::OP_INC_ACC |=>
      acc_q == $past(acc_q) + 8'h01 && skip_q == (acc_q == 8'h00) && flags_q[csu_pkg::FLG_Z] == skip_q)
    else $error("accumulator increment wrong");
  chk_dec_acc_zero: assert property (
    exec && op_q == csu_pkg::OP_DEC_ACC |=>
      acc_q == $past(acc_q) - 8'h01 && skip_q == (acc_q == 8'h00))
    else $error("accumulator decrement wrong");
  chk_inc_mem_store: assert property (
    exec && op_q == csu_pkg::OP_INC_MEM |-> mif.a_we && mif.a_wdata == mif.a_rdata + 8'h01
      ##1 skip_q == ($past(mif.a_wdata) == 8'h00))
    else $error("memory increment wrong");
  chk_dec_mem_store: assert property (
    exec && op_q == csu_pkg::OP_DEC_MEM |-> mif.a_we && mif.a_wdata == mif.a_rdata - 8'h01
      ##1 skip_q == ($past(mif.a_wdata) == 8'h00))
    else $error("memory decrement wrong");
  chk_skip_two_cycles: assert property (
    done_q && skip_q |-> s_squash_once)
    else $error("skip did not take two cycles");
  chk_noskip_one_cycle: assert property (
    done_q && !skip_q |-> ready_q && !squash_q)
    else $error("non-skip took extra cycle");
  chk_squash_quiet: assert property (
    squash_q |-> !mif.a_we && st_d == csu_pkg::CSU_ST_IDLE && !take)
    else $error("squashed instruction had an effect");
  chk_squash_no_state: assert property (
    squash_q && !sw_acc && !sw_flg |=>
      $stable(acc_q) && $stable(flags_q) && $stable(skipcnt_q) && !done_q)
    else $error("squashed instruction changed state");
  chk_borrow_flags: assert property (
    exec && is_cmp && !sw_flg |=>
      flags_q[csu_pkg::FLG_AC] == ($past(acc_q[3:0]) < $past(opnd[3:0])) &&
      flags_q[csu_pkg::FLG_OV] == (($past(acc_q[7]) ^ $past(opnd[7])) && ($past(acc_q[7]) ^ $past(res[7]))))
    else $error("borrow or overflow flag wrong");

endmodule : csu_top

// ==== test_conditional_skip_unit.sv ====
// test_conditional_skip_unit: self-checking bench for the conditional skip unit
`timescale 1ns/10ps
module test_conditional_skip_unit;
  // ==========================================================
  // design inputs and outputs
  logic clk;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic instr_valid;
  logic [3:0] instr_op;
  logic [7:0] instr_imm;
  logic [6:0] instr_maddr;
  logic [2:0] instr_bit;
  logic [7:0] io_value;
  logic instr_ready;
  logic exec_done;
  logic skip_req;
  logic squash;
  logic [7:0] accumulator;
  logic [3:0] flags;
  // ==========================================================
  // reference state
  logic [7:0] acc_m;
  logic [3:0] flags_m;
  logic [7:0] mem_m [128];
  logic [7:0] skips;
  int n_errors;
  int checks_done;
  logic [7:0] va [6] = '{8'h55, 8'h10, 8'h80, 8'h00, 8'h7F, 8'h23};
  logic [7:0] vb [6] = '{8'h55, 8'h20, 8'h01, 8'h00, 8'hFF, 8'h14};
  logic [7:0] vc [6] = '{8'hFF, 8'h0F, 8'h7F, 8'h01, 8'h00, 8'h80};

  csu_top csu_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_imm(instr_imm), .instr_maddr(instr_maddr), .instr_bit(instr_bit), .io_value(io_value),
    .instr_ready(instr_ready), .exec_done(exec_done), .skip_req(skip_req), .squash(squash),
    .accumulator(accumulator), .flags(flags));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // checking and closing
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // reference arithmetic, flags packed {ov, ac, c, z}
  function automatic logic [3:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    d = {1'b0, a} - {1'b0, b};
    return {(a[7] ^ b[7]) & (a[7] ^ d[7]), a[3:0] < b[3:0], d[8], d[7:0] == 8'h00};
  endfunction : sub_flags

  function automatic logic [3:0] inc_flags(input logic [7:0] a);
    return {a == 8'h7F, a[3:0] == 4'hF, a == 8'hFF, a == 8'hFF};
  endfunction : inc_flags

  task automatic predict(input logic [3:0] op, input logic [7:0] imm, input logic [6:0] ma,
                         input logic [2:0] bn, input logic [7:0] io, output logic sk);
    logic [7:0] m;
    m = mem_m[ma];
    sk = 1'b0;
    case (op)
      csu_pkg::OP_CEQ_IMM, csu_pkg::OP_CNE_IMM: begin
        flags_m = sub_flags(acc_m, imm);
        sk = (acc_m == imm) ^ (op == csu_pkg::OP_CNE_IMM);
      end
      csu_pkg::OP_CEQ_MEM, csu_pkg::OP_CNE_MEM: begin
        flags_m = sub_flags(acc_m, m);
        sk = (acc_m == m) ^ (op == csu_pkg::OP_CNE_MEM);
      end
      csu_pkg::OP_TLO_IO: sk = ~io[bn];
      csu_pkg::OP_THI_IO: sk = io[bn];
      csu_pkg::OP_TLO_MEM: sk = ~m[bn];
      csu_pkg::OP_THI_MEM: sk = m[bn];
      csu_pkg::OP_INC_ACC: begin
        flags_m = inc_flags(acc_m);
        acc_m = acc_m + 8'h01;
        sk = acc_m == 8'h00;
      end
      csu_pkg::OP_DEC_ACC: begin
        flags_m = sub_flags(acc_m, 8'h01);
        acc_m = acc_m - 8'h01;
        sk = acc_m == 8'h00;
      end
      csu_pkg::OP_INC_MEM: begin
        flags_m = inc_flags(m);
        mem_m[ma] = m + 8'h01;
        sk = mem_m[ma] == 8'h00;
      end
      csu_pkg::OP_DEC_MEM: begin
        flags_m = sub_flags(m, 8'h01);
        mem_m[ma] = m - 8'h01;
        sk = mem_m[ma] == 8'h00;
      end
      default: sk = 1'b0;
    endcase
    if (sk) skips = skips + 8'h01;
  endtask : predict
  // ==========================================================
  // register port and instruction issue
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(nm, reg_rdata, exp);
  endtask : reg_read

  task automatic set_acc_mem(input logic [7:0] a, input logic [6:0] ma, input logic [7:0] m);
    reg_write(csu_pkg::REG_ACC, a);
    reg_write(csu_pkg::REG_MADDR, {1'b0, ma});
    reg_write(csu_pkg::REG_MDATA, m);
    acc_m = a;
    mem_m[ma] = m;
  endtask : set_acc_mem

  // the follower offered during the squash cycle must be ignored
  task automatic exec(input logic [3:0] op, input logic [7:0] imm, input logic [6:0] ma,
                      input logic [2:0] bn, input logic [7:0] io);
    logic sk;
    int n;
    n = 0;
    predict(op, imm, ma, bn, io, sk);
    @(negedge clk);
    while (instr_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) check("ready_wait", 8'h00, 8'h01);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_imm <= imm;
    instr_maddr <= ma;
    instr_bit <= bn;
    io_value <= io;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    check("done_early", exec_done, 8'h00);
    @(posedge clk);
    if (sk) begin
      instr_valid <= 1'b1;
      instr_op <= csu_pkg::OP_INC_ACC;
    end
    @(negedge clk);
    check("done", exec_done, 8'h01);
    check("skip_req", skip_req, sk);
    check("squash", squash, sk);
    check("ready_c2", instr_ready, !sk);
    check("acc", accumulator, acc_m);
    check("flags", flags, flags_m);
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    check("squash_end", squash, 8'h00);
    check("ready_c3", instr_ready, 8'h01);
    check("acc_kept", accumulator, acc_m);
  endtask : exec
  // ==========================================================
  // stimulus
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    instr_valid = 1'b0;
    instr_op = 4'h0;
    instr_imm = 8'h00;
    instr_maddr = 7'h00;
    instr_bit = 3'h0;
    io_value = 8'h00;
    n_errors = 0;
    checks_done = 0;
    skips = 8'h00;
    acc_m = 8'h00;
    flags_m = 4'h0;
    repeat (5) @(posedge clk);
    check("rst_ready", instr_ready, 8'h00);
    check("rst_acc", accumulator, 8'h00);
    check("rst_flags", flags, 8'h00);
    rst_b <= 1'b1;
    reg_read(csu_pkg::REG_FLAGS, 8'h00, "flags_rst");
    reg_read(8'h40, 8'h00, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      for (int op = 0; op < 4; op++) begin
        set_acc_mem(va[i], 7'h10, vb[i]);
        exec(op[3:0], vb[i], 7'h10, 3'h0, 8'h00);
      end
    end
    reg_read(csu_pkg::REG_STATUS, 8'h01, "status_skip");
    reg_read(csu_pkg::REG_MADDR, 8'h10, "maddr_reg");
    $display("test compare done");
    set_acc_mem(8'h3C, 7'h11, 8'h5A);
    reg_write(csu_pkg::REG_FLAGS, 8'h0B);
    flags_m = 4'hB;
    for (int b = 0; b < 8; b++) begin
      for (int op = 4; op < 8; op++) begin
        exec(op[3:0], 8'h00, 7'h11, b[2:0], 8'hA5);
      end
    end
    $display("test bit done");
    for (int i = 0; i < 6; i++) begin
      for (int op = 8; op < 12; op++) begin
        set_acc_mem(vc[i], 7'h12, vc[i]);
        exec(op[3:0], 8'h00, 7'h12, 3'h0, 8'h00);
        reg_read(csu_pkg::REG_MDATA, mem_m[7'h12], "mem_byte");
      end
    end
    $display("test count done");
    exec(4'hC, 8'h00, 7'h12, 3'h0, 8'h00);
    reg_write(csu_pkg::REG_SKIPCNT, 8'hEE);
    reg_read(csu_pkg::REG_SKIPCNT, skips, "skip_count");
    reg_read(csu_pkg::REG_ACC, acc_m, "acc_reg");
    reg_read(csu_pkg::REG_FLAGS, {4'h0, flags_m}, "flags_reg");
    $display("test registers done");
    complete_run();
  end

  // about 720 cycles expected; limit allows a wide margin
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
endmodule : test_conditional_skip_unit
